// *** gtc_timer.sv ***
// general purpose 32-bit up/down timer with event capture, AHB-Lite slave
// assumes a single AHB-Lite master, inputs synchronous to hclk
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "gtc_params.svh"

// Overview of operation
// - A 32-bit read-only capture register holds the count latched on the chosen event.
// - Config bit 17 enables capture, and nothing is captured while it is clear.
// - Config bits 16-12 pick which of 32 event sources triggers a capture.
// - Config bits 11-9 pick core clock, 32.768 kHz oscillator, pin a or pin b as source.
// - Config bit 8 makes the count go up when set and down when clear, down after reset.
// - Config bit 7 runs the counter when set and stops it when clear, stopped after reset.
// - Config bit 6 selects periodic when set and free-running when clear.
// - Config bits 5-4 select binary, or time format ending at 23 or at 255 hours.
// - Config bits 3-0 divide the source by 1, 16, 256 or 32768.
// - The counter takes the reload value at terminal count in periodic mode, or at once on a refresh write.
// - On each rising edge of the chosen source the count is copied while counting goes on.
// - A write to the refresh register clears the timer interrupt flag unless a timeout sets it in the same cycle.
module gtc_timer
  import gtc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [31:0] irq_sources,
  input  wire logic        osc_32k,
  input  wire logic        ext_clock_pin_a,
  input  wire logic        ext_clock_pin_b,
  output logic             irq
);
  logic [31:0] reload_value_reg;
  logic [31:0] current_count_reg;
  logic [31:0] timer_config_reg;
  logic [31:0] captured_time_value_reg;
  logic [`GTC_IRQ_N-1:0] irq_stat_reg;
  logic [`GTC_IRQ_N-1:0] irq_en_reg;
  logic [31:0] addr_reg;
  logic        wr_reg;
  logic        act_reg;
  logic [2:0]  src_prev_reg;
  logic        evt_prev_reg;
  logic [14:0] presc_reg;
  logic [14:0] presc_top;
  logic        src_evt;
  logic        tick;
  logic        term;
  logic        timeout;
  logic        cap_evt;
  logic        wr_now;
  logic        refresh_wr;
  logic [7:0]  hours_max;
  logic [31:0] step_val;
  logic [31:0] rd_mux;
  logic [`GTC_IRQ_N-1:0] irq_evt;
  gtc_fmt_e    fmt;
  gtc_src_e    src;

  assign fmt = gtc_fmt_e'(timer_config_reg[5:4]);
  assign src = gtc_src_e'(timer_config_reg[11:9]);

  // one time-format step; fields hh:mm:ss:hh, one byte each
  function automatic logic [31:0] tm_step(input logic [31:0] v, input logic up, input logic [7:0] hmax);
    logic [31:0] r;
    r = v;
    if (up)
    begin
      if (v[7:0] != `GTC_HUND_LAST) r[7:0] = v[7:0] + 8'h01;
      else
      begin
        r[7:0] = 8'h00;
        if (v[15:8] != `GTC_MINSEC_LAST) r[15:8] = v[15:8] + 8'h01;
        else
        begin
          r[15:8] = 8'h00;
          if (v[23:16] != `GTC_MINSEC_LAST) r[23:16] = v[23:16] + 8'h01;
          else
          begin
            r[23:16] = 8'h00;
            r[31:24] = (v[31:24] == hmax) ? 8'h00 : v[31:24] + 8'h01;
          end
        end
      end
    end
    else
    begin
      if (v[7:0] != 8'h00) r[7:0] = v[7:0] - 8'h01;
      else
      begin
        r[7:0] = `GTC_HUND_LAST;
        if (v[15:8] != 8'h00) r[15:8] = v[15:8] - 8'h01;
        else
        begin
          r[15:8] = `GTC_MINSEC_LAST;
          if (v[23:16] != 8'h00) r[23:16] = v[23:16] - 8'h01;
          else
          begin
            r[23:16] = `GTC_MINSEC_LAST;
            r[31:24] = (v[31:24] == 8'h00) ? hmax : v[31:24] - 8'h01;
          end
        end
      end
    end
    return r;
  endfunction

  // ahb address phase capture; zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_reg <= 32'h00000000;
      wr_reg   <= 1'b0;
      act_reg  <= 1'b0;
    end
    else if (hready)
    begin
      addr_reg <= haddr;
      wr_reg   <= hwrite;
      act_reg  <= hsel && htrans[1];
    end
  end

  assign wr_now     = act_reg && wr_reg;
  assign refresh_wr = wr_now && (addr_reg == `GTC_OFS_REFRESH);

  // software registers; upper config bits are kept zero regardless of writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reload_value_reg <= 32'h00000000;
      timer_config_reg <= `GTC_CFG_RESET;
      irq_en_reg       <= '0;
    end
    else if (wr_now)
    begin
      if (addr_reg == `GTC_OFS_RELOAD) reload_value_reg <= hwdata;
      if (addr_reg == `GTC_OFS_CONFIG) timer_config_reg <= hwdata & `GTC_CFG_MASK;
      if (addr_reg == `GTC_OFS_IRQ_EN) irq_en_reg <= hwdata[`GTC_IRQ_N-1:0];
    end
  end

  // read data registered during the address phase
  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (haddr)
      `GTC_OFS_RELOAD:   rd_mux = reload_value_reg;
      `GTC_OFS_COUNT:    rd_mux = current_count_reg;
      `GTC_OFS_CONFIG:   rd_mux = timer_config_reg;
      `GTC_OFS_CAPTURE:  rd_mux = captured_time_value_reg;
      `GTC_OFS_IRQ_STAT: rd_mux = {30'h00000000, irq_stat_reg};
      `GTC_OFS_IRQ_EN:   rd_mux = {30'h00000000, irq_en_reg};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite) hrdata <= rd_mux;
    end
  end

  // source edge detect; slow sources count on their rising edges
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) src_prev_reg <= 3'h0;
    else src_prev_reg <= {ext_clock_pin_b, ext_clock_pin_a, osc_32k};
  end

  always_comb
  begin
    unique case (src)
      GTC_SRC_CORE:  src_evt = 1'b1;
      GTC_SRC_OSC:   src_evt = osc_32k && !src_prev_reg[0];
      GTC_SRC_PIN_A: src_evt = ext_clock_pin_a && !src_prev_reg[1];
      GTC_SRC_PIN_B: src_evt = ext_clock_pin_b && !src_prev_reg[2];
      default:       src_evt = 1'b0;
    endcase
  end

  // prescaler; undocumented codes behave as divide by one
  always_comb
  begin
    unique case (timer_config_reg[3:0])
      `GTC_PRE_DIV16:    presc_top = `GTC_TOP_DIV16;
      `GTC_PRE_DIV256:   presc_top = `GTC_TOP_DIV256;
      `GTC_PRE_DIV32768: presc_top = `GTC_TOP_DIV32768;
      default:           presc_top = 15'h0000;
    endcase
  end

  assign tick = timer_config_reg[`GTC_BIT_EN] && src_evt && (presc_reg >= presc_top);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) presc_reg <= 15'h0000;
    else if (!timer_config_reg[`GTC_BIT_EN] || tick) presc_reg <= 15'h0000;
    else if (src_evt) presc_reg <= presc_reg + 15'h0001;
  end

  // terminal count and next value for the chosen format
  assign hours_max = (fmt == GTC_FMT_T255) ? `GTC_HOURS_255 : `GTC_HOURS_23;
  always_comb
  begin
    if (fmt[1])
    begin
      step_val = tm_step(current_count_reg, timer_config_reg[`GTC_BIT_UP], hours_max);
      term = timer_config_reg[`GTC_BIT_UP] ?
             (current_count_reg == {hours_max, `GTC_MINSEC_LAST, `GTC_MINSEC_LAST, `GTC_HUND_LAST}) :
             (current_count_reg == 32'h00000000);
    end
    else
    begin
      step_val = timer_config_reg[`GTC_BIT_UP] ? current_count_reg + 32'h00000001 :
                 current_count_reg - 32'h00000001;
      term = timer_config_reg[`GTC_BIT_UP] ? (current_count_reg == 32'hffffffff) :
             (current_count_reg == 32'h00000000);
    end
  end

  assign timeout = tick && term;

  // counter; a refresh write outranks a tick in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) current_count_reg <= 32'h00000000;
    else if (refresh_wr) current_count_reg <= reload_value_reg;
    else if (tick)
    begin
      if (term && timer_config_reg[`GTC_BIT_PERIODIC]) current_count_reg <= reload_value_reg;
      else current_count_reg <= step_val;
    end
  end

  // capture on the rising edge of the selected source only
  assign cap_evt = timer_config_reg[`GTC_BIT_CAP_EN] && irq_sources[timer_config_reg[16:12]]
                   && !evt_prev_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      evt_prev_reg            <= 1'b0;
      captured_time_value_reg <= 32'h00000000;
    end
    else
    begin
      evt_prev_reg <= irq_sources[timer_config_reg[16:12]];
      if (cap_evt) captured_time_value_reg <= current_count_reg;
    end
  end

  // sticky status; a new event wins over a clear in the same cycle
  assign irq_evt[`GTC_IRQ_TIMEOUT] = timeout;
  assign irq_evt[`GTC_IRQ_CAPTURE] = cap_evt;
  genvar gi;
  generate
    for (gi = 0; gi < `GTC_IRQ_N; gi++)
    begin : g_stat
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn) irq_stat_reg[gi] <= 1'b0;
        else if (irq_evt[gi]) irq_stat_reg[gi] <= 1'b1;
        else if (wr_now && addr_reg == `GTC_OFS_IRQ_CLR && hwdata[gi]) irq_stat_reg[gi] <= 1'b0;
        else if (refresh_wr && gi == `GTC_IRQ_TIMEOUT) irq_stat_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  // level interrupt, registered so it lags status by a cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) irq <= 1'b0;
    else irq <= |(irq_stat_reg & irq_en_reg);
  end

  property p_cap_copy;
    @(posedge hclk) disable iff (!hresetn) cap_evt |=> captured_time_value_reg == $past(current_count_reg);
  endproperty
  a_cap_copy: assert property (p_cap_copy) else $error("capture missed count");

  property p_cap_off;
    @(posedge hclk) disable iff (!hresetn) !timer_config_reg[`GTC_BIT_CAP_EN] |=> $stable(captured_time_value_reg);
  endproperty
  a_cap_off: assert property (p_cap_off) else $error("capture while disabled");

  // any change of the capture register must follow a fresh rise of the selected source
  property p_cap_sel;
    @(posedge hclk) disable iff (!hresetn)
      $changed(captured_time_value_reg) |-> $past(timer_config_reg[`GTC_BIT_CAP_EN])
      && $past(irq_sources[timer_config_reg[16:12]]) && !$past(irq_sources[timer_config_reg[16:12]], 2);
  endproperty
  a_cap_sel: assert property (p_cap_sel) else $error("capture from wrong source");

  property p_stop;
    @(posedge hclk) disable iff (!hresetn)
      !timer_config_reg[`GTC_BIT_EN] && !refresh_wr |=> $stable(current_count_reg);
  endproperty
  a_stop: assert property (p_stop) else $error("count moved while stopped");

  property p_refresh;
    @(posedge hclk) disable iff (!hresetn) refresh_wr |=> current_count_reg == $past(reload_value_reg);
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh did not reload");

  property p_refresh_clr;
    @(posedge hclk) disable iff (!hresetn) refresh_wr && !timeout |=> !irq_stat_reg[`GTC_IRQ_TIMEOUT];
  endproperty
  a_refresh_clr: assert property (p_refresh_clr) else $error("refresh left flag set");

  property p_down;
    @(posedge hclk) disable iff (!hresetn)
      tick && !refresh_wr && !fmt[1] && !timer_config_reg[`GTC_BIT_UP] && !term
      |=> current_count_reg == $past(current_count_reg) - 32'h00000001;
  endproperty
  a_down: assert property (p_down) else $error("binary down step wrong");

  property p_free_wrap;
    @(posedge hclk) disable iff (!hresetn)
      timeout && !refresh_wr && !fmt[1] && !timer_config_reg[`GTC_BIT_UP] && !timer_config_reg[`GTC_BIT_PERIODIC]
      |=> current_count_reg == 32'hffffffff;
  endproperty
  a_free_wrap: assert property (p_free_wrap) else $error("free-running did not wrap");

  property p_hund;
    @(posedge hclk) disable iff (!hresetn)
      tick && !refresh_wr && fmt[1] && timer_config_reg[`GTC_BIT_UP] && !term
      && current_count_reg[7:0] == `GTC_HUND_LAST |=> current_count_reg[7:0] == 8'h00;
  endproperty
  a_hund: assert property (p_hund) else $error("hundredths did not roll");

  property p_div16;
    @(posedge hclk) disable iff (!hresetn)
      tick && timer_config_reg[3:0] == `GTC_PRE_DIV16 && src == GTC_SRC_CORE
      ##1 (timer_config_reg[3:0] == `GTC_PRE_DIV16 && src == GTC_SRC_CORE
           && timer_config_reg[`GTC_BIT_EN])[*8] |-> !tick;
  endproperty
  a_div16: assert property (p_div16) else $error("divide by 16 ticked early");

  c_capture: cover property (@(posedge hclk) disable iff (!hresetn) cap_evt);
  c_periodic: cover property (@(posedge hclk) disable iff (!hresetn) timeout && timer_config_reg[`GTC_BIT_PERIODIC]);
  c_time_fmt: cover property (@(posedge hclk) disable iff (!hresetn) tick && fmt[1]);
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) irq);
endmodule
`default_nettype wire

// *** gtc_params.svh ***
// constants of the general timer with capture: offsets, fields, resets
// assumes inclusion by the timer module and the testbench only
`ifndef GTC_PARAMS_SVH
`define GTC_PARAMS_SVH
`define GTC_OFS_RELOAD     32'hffff0380
`define GTC_OFS_COUNT      32'hffff0384
`define GTC_OFS_CONFIG     32'hffff0388
`define GTC_OFS_REFRESH    32'hffff038c
`define GTC_OFS_CAPTURE    32'hffff0390
`define GTC_OFS_IRQ_STAT   32'hffff0394
`define GTC_OFS_IRQ_EN     32'hffff0398
`define GTC_OFS_IRQ_CLR    32'hffff039c
`define GTC_CFG_RESET      32'h00000000
`define GTC_CFG_MASK       32'h0003ffff
`define GTC_BIT_CAP_EN     17
`define GTC_BIT_UP         8
`define GTC_BIT_EN         7
`define GTC_BIT_PERIODIC   6
`define GTC_PRE_DIV1       4'h0
`define GTC_PRE_DIV16      4'h4
`define GTC_PRE_DIV256     4'h8
`define GTC_PRE_DIV32768   4'hf
`define GTC_TOP_DIV16      15'h000f
`define GTC_TOP_DIV256     15'h00ff
`define GTC_TOP_DIV32768   15'h7fff
`define GTC_HUND_LAST      8'h63
`define GTC_MINSEC_LAST    8'h3b
`define GTC_HOURS_23       8'h17
`define GTC_HOURS_255      8'hff
`define GTC_IRQ_TIMEOUT    0
`define GTC_IRQ_CAPTURE    1
`define GTC_IRQ_N          2
`endif

// *** gtc_pkg.sv ***
// types of the general timer with capture
// assumes nothing beyond the constants header
package gtc_pkg;
  typedef enum logic [2:0] {
    GTC_SRC_CORE  = 3'h0,
    GTC_SRC_OSC   = 3'h1,
    GTC_SRC_PIN_A = 3'h2,
    GTC_SRC_PIN_B = 3'h3
  } gtc_src_e;
  typedef enum logic [1:0] {
    GTC_FMT_BIN   = 2'h0,
    GTC_FMT_RSVD  = 2'h1,
    GTC_FMT_T23   = 2'h2,
    GTC_FMT_T255  = 2'h3
  } gtc_fmt_e;
endpackage

// *** general_timer_with_capture_tb.sv ***
// self-checking bench for the general timer with capture, ahb-lite register access
// assumes gtc_timer as the single slave, hready looped back from hreadyout
`timescale 1ns/1ps
`default_nettype none
`include "gtc_params.svh"

module general_timer_with_capture_tb
  import gtc_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] srcs = 32'h0;
  logic [2:0]  ext = 3'h0;
  logic        irq;
  int          err_total = 0;
  int          cmp_count = 0;
  int          seed = 65;
  int          cyc = 0;
  int          ecyc;
  int          d;
  int          k;
  int          n;
  logic [31:0] r;
  logic [31:0] v;
  logic [4:0]  s5;
  logic        up;
  logic        per;

  // 50 ns period, cycle count marks when writes land
  always #25 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  gtc_timer uut (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .hsel            (hsel),
    .haddr           (haddr),
    .htrans          (htrans),
    .hwrite          (hwrite),
    .hsize           (3'h2),
    .hwdata          (hwdata),
    .hready          (hreadyout),
    .hrdata          (hrdata),
    .hreadyout       (hreadyout),
    .hresp           (hresp),
    .irq_sources     (srcs),
    .osc_32k         (ext[0]),
    .ext_clock_pin_a (ext[1]),
    .ext_clock_pin_b (ext[2]),
    .irq             (irq)
  );

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single transfer; idle cycle before it so no write/read overlap
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] dat, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dat;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd   = hrdata;
    ecyc = cyc;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] dat);
    logic [31:0] dummy;
    bus(1'b1, a, dat, dummy);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, a, 32'h0, got);
    chk(got, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  function automatic logic [31:0] mk(input logic [4:0] sel, input logic cap, input logic [2:0] src,
                                     input logic u, input logic p, input logic [1:0] fmt, input logic [3:0] pre);
    return {14'h0, cap, sel, src, u, 1'b0, p, fmt, pre};
  endfunction

  // time format as total hundredths and back, fields are plain binary bytes
  function automatic longint tval(input logic [31:0] t);
    return ((longint'(t[31:24]) * 60 + t[23:16]) * 60 + t[15:8]) * 100 + t[7:0];
  endfunction

  function automatic logic [31:0] tconv(input longint x);
    return {8'(x / 360000), 8'((x / 6000) % 60), 8'((x / 100) % 60), 8'(x % 100)};
  endfunction

  // load, refresh, run for a span, stop; returns edges the counter ran
  task automatic run(input logic [31:0] c, input logic [31:0] rl, input int cycles, output int dd);
    int e1;
    wr(`GTC_OFS_RELOAD, rl);
    wr(`GTC_OFS_REFRESH, 32'h0);
    wr(`GTC_OFS_CONFIG, c | 32'h80);
    e1 = ecyc;
    repeat (cycles) @(posedge hclk);
    wr(`GTC_OFS_CONFIG, c);
    dd = ecyc - e1;
  endtask

  // hang guard, far beyond the expected run of some 1.5k cycles
  initial
  begin
    repeat (60000) @(posedge hclk);
    err_total++;
    complete_run();
  end

  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values and read-only or unmapped places
    rd_chk(`GTC_OFS_CONFIG, `GTC_CFG_RESET);
    rd_chk(`GTC_OFS_CAPTURE, 32'h0);
    rd_chk(`GTC_OFS_COUNT, 32'h0);
    rd_chk(`GTC_OFS_IRQ_STAT, 32'h0);
    rd_chk(32'hffff03a0, 32'h0);
    v = $random(seed);
    wr(`GTC_OFS_CAPTURE, v);
    rd_chk(`GTC_OFS_CAPTURE, 32'h0);
    wr(`GTC_OFS_CONFIG, v & 32'hffffff7f & `GTC_CFG_MASK);
    rd_chk(`GTC_OFS_CONFIG, v & 32'hffffff7f & `GTC_CFG_MASK);
    wr(`GTC_OFS_CONFIG, 32'h0);
    $display("test reset and access done");
    // direction and mode, wrap or reload at terminal count, flag and interrupt
    wr(`GTC_OFS_IRQ_EN, 32'h3);
    for (int i = 0; i < 4; i++)
    begin
      up  = i[1];
      per = i[0];
      k   = 5 + ($unsigned($random(seed)) % 12);
      r   = up ? 32'hffffffff - k : 32'(k);
      run(mk(5'h0, 1'b0, 3'h0, up, per, 2'h0, 4'h0), r, 30, d);
      if (!up)
        rd_chk(`GTC_OFS_COUNT, per ? r - (d % (k + 1)) : r - d);
      else
        rd_chk(`GTC_OFS_COUNT, per ? r + (d % (k + 1)) : r + d);
      rd_chk(`GTC_OFS_IRQ_STAT, {31'h0, d > k});
      chk({31'h0, irq}, {31'h0, d > k});
      wr(`GTC_OFS_REFRESH, $random(seed));
      rd_chk(`GTC_OFS_COUNT, r);
      rd_chk(`GTC_OFS_IRQ_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    // masking and the clear register
    run(32'h0, 32'h3, 20, d);
    // irq is registered off the enable register, so it settles one edge after the write lands
    wr(`GTC_OFS_IRQ_EN, 32'h0);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    wr(`GTC_OFS_IRQ_EN, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    wr(`GTC_OFS_IRQ_CLR, 32'h1);
    rd_chk(`GTC_OFS_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test count modes done");
    // divider codes; each shift pairs with its code
    for (int sh = 0; sh <= 8; sh += 4)
    begin
      run(mk(5'h0, 1'b0, 3'h0, 1'b0, 1'b0, 2'h0, 4'(sh)), 32'd1000, 3 * (1 << sh) + 5, d);
      rd_chk(`GTC_OFS_COUNT, 32'd1000 - (d >> sh));
    end
    $display("test divider done");
    // time format carries in both directions
    r = {8'h01, 8'h3b, 8'h3b, 8'h5a};
    run(mk(5'h0, 1'b0, 3'h0, 1'b1, 1'b0, GTC_FMT_T23, 4'h0), r, 25, d);
    rd_chk(`GTC_OFS_COUNT, tconv(tval(r) + d));
    r = {8'h02, 8'h00, 8'h00, 8'h05};
    run(mk(5'h0, 1'b0, 3'h0, 1'b0, 1'b0, GTC_FMT_T255, 4'h0), r, 25, d);
    rd_chk(`GTC_OFS_COUNT, tconv(tval(r) - d));
    $display("test time format done");
    // slow sources: only the chosen input may count, the others pulse extra
    wr(`GTC_OFS_RELOAD, 32'h100);
    for (int s = 1; s < 4; s++)
    begin
      n = 2 + ($unsigned($random(seed)) % 6);
      wr(`GTC_OFS_REFRESH, 32'h0);
      wr(`GTC_OFS_CONFIG, mk(5'h0, 1'b0, 3'(s), 1'b1, 1'b0, 2'h0, 4'h0) | 32'h80);
      for (int j = 0; j < 2 * n; j++)
      begin
        ext <= (j < n) ? 3'h7 : ~(3'h1 << (s - 1));
        repeat (2) @(posedge hclk);
        ext <= 3'h0;
        repeat (2) @(posedge hclk);
      end
      repeat (4) @(posedge hclk);
      wr(`GTC_OFS_CONFIG, 32'h0);
      rd_chk(`GTC_OFS_COUNT, 32'h100 + n);
    end
    $display("test sources done");
    // capture with the counter held so the latched value is exact
    v  = $random(seed);
    s5 = 5'($random(seed));
    wr(`GTC_OFS_RELOAD, v);
    wr(`GTC_OFS_REFRESH, 32'h0);
    wr(`GTC_OFS_CONFIG, mk(s5, 1'b0, 3'h0, 1'b0, 1'b0, 2'h0, 4'h0));
    srcs <= 32'h1 << s5;
    repeat (3) @(posedge hclk);
    rd_chk(`GTC_OFS_CAPTURE, 32'h0);
    srcs <= 32'h0;
    wr(`GTC_OFS_CONFIG, mk(s5, 1'b1, 3'h0, 1'b0, 1'b0, 2'h0, 4'h0));
    srcs <= 32'h1 << (s5 ^ 5'h1);
    repeat (3) @(posedge hclk);
    rd_chk(`GTC_OFS_CAPTURE, 32'h0);
    srcs <= (32'h1 << s5) | (32'h1 << (s5 ^ 5'h1));
    repeat (3) @(posedge hclk);
    rd_chk(`GTC_OFS_CAPTURE, v);
    rd_chk(`GTC_OFS_IRQ_STAT, 32'h2);
    wr(`GTC_OFS_RELOAD, ~v);
    wr(`GTC_OFS_REFRESH, 32'h0);
    rd_chk(`GTC_OFS_CAPTURE, v);
    srcs <= 32'h0;
    @(posedge hclk);
    srcs <= 32'h1 << s5;
    repeat (3) @(posedge hclk);
    rd_chk(`GTC_OFS_CAPTURE, ~v);
    $display("test capture done");
    complete_run();
  end
endmodule

`default_nettype wire
